// >>> rtl/scb_cmd_defines.vh
// Register offsets, field positions, codes and reset values of the command word block.
`ifndef SCB_CMD_DEFINES_VH
`define SCB_CMD_DEFINES_VH

// ----------------------------------------------------------------------------
// Register word indexes and byte addresses (index times four).
// ----------------------------------------------------------------------------
`define STATUS_WORD_IDX   8'h00
`define CMD_WORD_IDX      8'h02
`define GEN_PTR_IDX       8'h04
`define CU_BASE_IDX       8'h05
`define DUMP_ADDR_IDX     8'h06
`define UNIT_CTRL_IDX     8'h07
`define STATUS_WORD_ADDR  8'h00
`define CMD_WORD_ADDR     8'h08
`define GEN_PTR_ADDR      8'h10
`define CU_BASE_ADDR      8'h14
`define DUMP_ADDR_ADDR    8'h18
`define UNIT_CTRL_ADDR    8'h1C

// ----------------------------------------------------------------------------
// Command word fields.
// ----------------------------------------------------------------------------
`define MASK_HI           15
`define MASK_LO           10
`define SW_INT_BIT        9
`define GLOBAL_MASK_BIT   8
`define OP_HI             7
`define OP_LO             4
`define CMD_WORD_RESET    16'h0000

// ----------------------------------------------------------------------------
// Status word fields: six event flags, software flag, unit state.
// ----------------------------------------------------------------------------
`define STAT_CX_BIT       15
`define STAT_SW_BIT       10
`define STAT_CUS_HI       7
`define STAT_CUS_LO       6

// ----------------------------------------------------------------------------
// Command unit opcodes.
// ----------------------------------------------------------------------------
`define OP_NOP            4'h0
`define OP_START          4'h1
`define OP_RESUME         4'h2
`define OP_HPQ_START      4'h3
`define OP_LOAD_DUMP      4'h4
`define OP_DUMP           4'h5
`define OP_LOAD_BASE      4'h6

// ----------------------------------------------------------------------------
// Command unit states.
// ----------------------------------------------------------------------------
`define CUS_IDLE          2'h0
`define CUS_SUSP          2'h1
`define CUS_LPQ           2'h2
`define CUS_HPQ           2'h3

`endif

// >>> rtl/event_flags.v
// Sticky event flags with write-one-to-clear, where a set beats a clear.
`timescale 1ns/1ns
`default_nettype none
module event_flags (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [6:0] set_in,
  input  wire [6:0] clr_in,
  output wire [6:0] flags
);
  reg [6:0] flag_r;

  // ----------------------------------------------------------------------------
  // One flag per event source.
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1) begin : g_flag
      // The flag holds until written with one; an event in that cycle wins.
      always @(posedge aclk) begin
        if (!aresetn)
          flag_r[i] <= 1'b0;
        else if (set_in[i])
          flag_r[i] <= 1'b1;
        else if (clr_in[i])
          flag_r[i] <= 1'b0;
      end
    end
  endgenerate

  assign flags = flag_r;
endmodule // event_flags
`default_nettype wire

// >>> rtl/cmd_unit_fsm.v
// Command unit state machine stepped by command opcodes and completion events.
`timescale 1ns/1ns
`include "scb_cmd_defines.vh"
`default_nettype none
module cmd_unit_fsm (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       op_valid,
  input  wire [3:0] op_code,
  input  wire       list_done,
  input  wire       list_suspend,
  output reg  [1:0] state_r,
  output wire       left_active
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_SUSP = 2'b01;
  localparam [1:0] S_LPQ  = 2'b10;
  localparam [1:0] S_HPQ  = 2'b11;

  reg [1:0] state_nxt;

  // Next state from the opcode or from the end of a list.
  always @* begin
    state_nxt = state_r;
    if (op_valid) begin
      case (op_code)
        `OP_START:     state_nxt = S_LPQ;
        `OP_HPQ_START: state_nxt = S_HPQ;
        `OP_RESUME: begin
          if (state_r == S_SUSP)
            state_nxt = S_LPQ;
        end
        default:       state_nxt = state_r;
      endcase
    end else if (state_r[1]) begin
      if (list_done)
        state_nxt = S_IDLE;
      else if (list_suspend)
        state_nxt = S_SUSP;
    end
  end

  // State register.
  always @(posedge aclk) begin
    if (!aresetn)
      state_r <= S_IDLE;
    else
      state_r <= state_nxt;
  end

  // Pulses one cycle as the unit drops out of an active state.
  assign left_active = state_r[1] & ~state_nxt[1];
endmodule // cmd_unit_fsm
`default_nettype wire

// >>> rtl/system_command_word.v
// Command word register block of the system control block behind an AXI4-Lite slave.
`timescale 1ns/1ns
`include "scb_cmd_defines.vh"
`default_nettype none
module system_command_word (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Event inputs from the rest of the controller, one-cycle pulses.
  input  wire        cmd_done_ev,
  input  wire        rx_packet_done_ev,
  input  wire        rx_not_ready_ev,
  input  wire        early_rx_ev,
  input  wire        flow_pause_ev,
  input  wire        list_done,
  input  wire        list_suspend,
  // Command actions towards the command unit, unit state and interrupt line.
  output reg         cu_start_r,
  output reg         cu_resume_r,
  output reg         hpq_start_r,
  output reg         dump_req_r,
  output reg  [31:0] list_ptr_r,
  output reg  [31:0] dump_addr_r,
  output reg  [31:0] cu_base_r,
  output reg  [1:0]  cmd_unit_state,
  output reg         inta_n_r
);

  // --------------------------------------------------------------------------
  // Registers and wires.
  // --------------------------------------------------------------------------
  reg  [15:0] cmd_word_r;
  reg  [31:0] gen_ptr_r;
  reg  [7:0]  aw_addr_r;
  reg         aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_held_r;
  reg         op_valid_r;
  reg  [3:0]  op_code_r;
  reg         sw_trig_r;
  reg  [6:0]  clr_r;
  wire [6:0]  flags;
  wire [1:0]  cu_state;
  wire        left_active;
  wire        wr_go;
  wire [7:0]  wr_idx;
  wire [15:0] cmd_rd;
  wire [15:0] stat_rd;
  wire [5:0]  src_pend;
  wire        irq_any;

  assign wr_go  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_idx = {2'b00, aw_addr_r[7:2]};

  // --------------------------------------------------------------------------
  // Write channel: address and data taken in either order.
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_idx)
          `STATUS_WORD_IDX, `CMD_WORD_IDX, `GEN_PTR_IDX,
          `CU_BASE_IDX, `DUMP_ADDR_IDX: s_axi_bresp <= 2'b00;
          default:                      s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register writes, opcode decode and flag clears.
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_word_r <= `CMD_WORD_RESET;
      gen_ptr_r  <= 32'h0000_0000;
      op_valid_r <= 1'b0;
      op_code_r  <= `OP_NOP;
      sw_trig_r  <= 1'b0;
      clr_r      <= 7'h00;
    end else begin
      op_valid_r <= 1'b0;
      sw_trig_r  <= 1'b0;
      clr_r      <= 7'h00;
      if (wr_go) begin
        case (wr_idx)
          `CMD_WORD_IDX: begin
            if (w_strb_r[1]) begin
              cmd_word_r[15:10]             <= w_data_r[15:10];
              cmd_word_r[`GLOBAL_MASK_BIT]  <= w_data_r[8];
              sw_trig_r                     <= w_data_r[9];
            end
            if (w_strb_r[0]) begin
              op_valid_r <= 1'b1;
              op_code_r  <= w_data_r[`OP_HI:`OP_LO];
              cmd_word_r[7:0] <= w_data_r[7:0];
            end
          end
          `STATUS_WORD_IDX: begin
            if (w_strb_r[1])
              clr_r <= {w_data_r[15:12], 1'b0, w_data_r[8], w_data_r[10]};
            if (w_strb_r[1] & w_data_r[9])
              clr_r[2] <= 1'b1;
          end
          `GEN_PTR_IDX: begin
            if (w_strb_r[0]) gen_ptr_r[7:0]   <= w_data_r[7:0];
            if (w_strb_r[1]) gen_ptr_r[15:8]  <= w_data_r[15:8];
            if (w_strb_r[2]) gen_ptr_r[23:16] <= w_data_r[23:16];
            if (w_strb_r[3]) gen_ptr_r[31:24] <= w_data_r[31:24];
          end
          default: begin
            op_valid_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command pulses decoded from the latched opcode; pointer loads taken from the general pointer.
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cu_start_r  <= 1'b0;
      cu_resume_r <= 1'b0;
      hpq_start_r <= 1'b0;
      dump_req_r  <= 1'b0;
      list_ptr_r  <= 32'h0000_0000;
      dump_addr_r <= 32'h0000_0000;
      cu_base_r   <= 32'h0000_0000;
    end else begin
      cu_start_r  <= op_valid_r & (op_code_r == `OP_START);
      hpq_start_r <= op_valid_r & (op_code_r == `OP_HPQ_START);
      cu_resume_r <= op_valid_r & (op_code_r == `OP_RESUME) &
                     (cu_state == `CUS_SUSP);
      dump_req_r  <= op_valid_r & (op_code_r == `OP_DUMP);
      if (op_valid_r & ((op_code_r == `OP_START) | (op_code_r == `OP_HPQ_START)))
        list_ptr_r <= gen_ptr_r;
      if (op_valid_r & (op_code_r == `OP_LOAD_DUMP))
        dump_addr_r <= gen_ptr_r;
      if (op_valid_r & (op_code_r == `OP_LOAD_BASE))
        cu_base_r <= gen_ptr_r;
    end
  end

  // --------------------------------------------------------------------------
  // Command unit state and sticky flags.
  // --------------------------------------------------------------------------
  cmd_unit_fsm u_fsm (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .op_valid     (op_valid_r),
    .op_code      (op_code_r),
    .list_done    (list_done),
    .list_suspend (list_suspend),
    .state_r      (cu_state),
    .left_active  (left_active)
  );

  // Flag order: cx, fr, cna, rnr, er, fcp, software.
  event_flags u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_in  ({cmd_done_ev, rx_packet_done_ev, left_active, rx_not_ready_ev,
               early_rx_ev, flow_pause_ev, sw_trig_r}),
    .clr_in  (clr_r),
    .flags   (flags)
  );

  // --------------------------------------------------------------------------
  // Interrupt line, registered and active low.
  // --------------------------------------------------------------------------
  assign src_pend = flags[6:1] & ~cmd_word_r[`MASK_HI:`MASK_LO];
  assign irq_any  = (|src_pend) | flags[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      inta_n_r       <= 1'b1;
      cmd_unit_state <= `CUS_IDLE;
    end else begin
      inta_n_r       <= ~(irq_any & ~cmd_word_r[`GLOBAL_MASK_BIT]);
      cmd_unit_state <= cu_state;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel.
  // --------------------------------------------------------------------------
  assign cmd_rd  = {cmd_word_r[15:10], 1'b0, cmd_word_r[8:0]};
  assign stat_rd = {flags[6:3], 1'b0, flags[0], flags[2], flags[1], cu_state, 6'h00};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `STATUS_WORD_ADDR: s_axi_rdata <= {16'h0000, stat_rd};
          `CMD_WORD_ADDR:    s_axi_rdata <= {16'h0000, cmd_rd};
          `GEN_PTR_ADDR:     s_axi_rdata <= gen_ptr_r;
          `CU_BASE_ADDR:     s_axi_rdata <= cu_base_r;
          `DUMP_ADDR_ADDR:   s_axi_rdata <= dump_addr_r;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // system_command_word
`default_nettype wire

// >>> tb/scb_cmd_asserts.sv
// Checker of bus answers, interrupt masking and opcode effects of the command word block.
`timescale 1ns/1ns
`include "scb_cmd_defines.vh"
`default_nettype none
module scb_cmd_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        cmd_done_ev,
  input wire logic        cu_start_r,
  input wire logic        cu_resume_r,
  input wire logic        hpq_start_r,
  input wire logic [1:0]  cmd_unit_state,
  input wire logic        inta_n_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] aa_r;
  logic [7:0] wd_r;
  logic [7:0] cw_r;
  logic       wp_r;
  logic       gm;
  assign gm = cw_r[0];
  // Tracks the upper byte of the command word and whether a write is still in flight.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aa_r <= 8'h00;
      wd_r <= 8'h00;
      cw_r <= 8'h00;
      wp_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aa_r <= s_axi_awaddr;
        wp_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[15:8];
      if (s_axi_bvalid && s_axi_bready) begin
        wp_r <= 1'b0;
        if (aa_r == `CMD_WORD_ADDR) cw_r <= wd_r;
      end
    end
  end
  sequence s_cmd_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `CMD_WORD_ADDR;
  endsequence
  sequence s_line_low;
    ##[1:3] !inta_n_r;
  endsequence
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("Write address ready stood longer than one cycle.");
  AST_WRITE_ANSWER: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("Write response did not follow the data.");
  AST_TRIGGER_READS_ZERO: assert property (s_cmd_read |=> s_axi_rvalid && !s_axi_rdata[9])
    else $error("Software trigger bit read back as one or read answer late.");
  AST_GMASK_WINS: assert property (gm && !wp_r && $past(gm, 3) |-> inta_n_r)
    else $error("Interrupt line asserted under the global mask.");
  AST_EVENT_RAISES: assert property (cmd_done_ev && !cw_r[7] && !gm && !wp_r |-> s_line_low)
    else $error("Unmasked command-done event did not assert the line.");
  AST_START_STATE: assert property (cu_start_r |-> ##[0:2] cmd_unit_state == 2'h2)
    else $error("Start did not make the low queue active.");
  AST_HPQ_STATE: assert property (hpq_start_r |-> ##[0:2] cmd_unit_state == 2'h3)
    else $error("High queue start did not make the high queue active.");
  AST_RESUME_STATE: assert property (cu_resume_r |-> ##[0:2] cmd_unit_state == 2'h2)
    else $error("Resume did not reactivate the unit.");
  AST_START_PULSE: assert property (cu_start_r || hpq_start_r |=> !(cu_start_r || hpq_start_r))
    else $error("Start pulse stood longer than one cycle.");
endmodule // scb_cmd_asserts

bind system_command_word scb_cmd_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .cmd_done_ev(cmd_done_ev), .cu_start_r(cu_start_r), .cu_resume_r(cu_resume_r), .hpq_start_r(hpq_start_r),
  .cmd_unit_state(cmd_unit_state), .inta_n_r(inta_n_r));
`default_nettype wire

// >>> tb/cmd_unit_model.sv
// Behavioural command unit that ends or suspends each started list after a short or long delay.
`timescale 1ns/1ns
`default_nettype none
module cmd_unit_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic suspend,
  output logic      list_done,
  output logic      list_suspend
);
  int cnt_r;
  // Counts down from each start and then ends or suspends the list with one pulse.
  always @(posedge aclk) begin
    list_done <= 1'b0;
    list_suspend <= 1'b0;
    if (!aresetn) cnt_r <= 0;
    else if (go) cnt_r <= slow ? 30 : 4;
    else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
      if (cnt_r == 1) begin
        list_done <= !suspend;
        list_suspend <= suspend;
      end
    end
  end
endmodule // cmd_unit_model
`default_nettype wire

// >>> tb/test_lan_system_command_word.sv
// Self-checking bench: bus tasks, event pulses, opcode scenarios and a command unit model.
`timescale 1ns/1ns
`include "scb_cmd_defines.vh"
`default_nettype none
module test_lan_system_command_word;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, susp = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, p, list_ptr_r, dump_addr_r, cu_base_r, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, list_done, list_suspend;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, inta_n_r;
  logic        cu_start_r, cu_resume_r, hpq_start_r, dump_req_r;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cmd_unit_state;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [4:0]  ev = 5'h00;
  logic [15:0] m;
  logic [15:0] mk [5] = '{16'h8000, 16'h4000, 16'h1000, 16'h0800, 16'h0400};
  logic [15:0] st [5] = '{16'h8000, 16'h4000, 16'h1000, 16'h0200, 16'h0100};
  logic [15:0] cl [5] = '{16'h8000, 16'h4000, 16'h1000, 16'h0200, 16'h0100};
  logic [33:0] q [$];
  int          n_fail = 0, check_count = 0, seed = 18742, i, cnt [4] = '{0, 0, 0, 0};
  wire logic   cmd_done_ev, rx_packet_done_ev, rx_not_ready_ev, early_rx_ev, flow_pause_ev;
  assign {cmd_done_ev, rx_packet_done_ev, rx_not_ready_ev, early_rx_ev, flow_pause_ev} = ev;
  always #20 aclk = ~aclk;
  system_command_word u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_done_ev,
    .rx_packet_done_ev, .rx_not_ready_ev, .early_rx_ev, .flow_pause_ev, .list_done, .list_suspend, .cu_start_r,
    .cu_resume_r, .hpq_start_r, .dump_req_r, .list_ptr_r, .dump_addr_r, .cu_base_r, .cmd_unit_state, .inta_n_r);
  cmd_unit_model u_cu (.aclk, .aresetn, .go(cu_start_r | cu_resume_r | hpq_start_r), .slow, .suspend(susp),
    .list_done, .list_suspend);
  // ----------------------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int t;
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input logic [4:0] v);
    ev <= v;
    @(posedge aclk);
    ev <= 5'h00;
    tk(4);
  endtask
  task automatic op(input logic [31:0] ptr, input logic [15:0] c);
    wr(`GEN_PTR_ADDR, ptr, 2'h0);
    wr(`CMD_WORD_ADDR, {16'h0, c}, 2'h0);
    tk(4);
  endtask
  task automatic wst(input logic [1:0] s);
    for (int t = 0; t < 100 && cmd_unit_state !== s; t++) @(posedge aclk);
    chk(cmd_unit_state, s);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Counts the command pulses towards the command unit.
  always @(posedge aclk) begin
    cnt[0] <= cnt[0] + cu_start_r;
    cnt[1] <= cnt[1] + cu_resume_r;
    cnt[2] <= cnt[2] + hpq_start_r;
    cnt[3] <= cnt[3] + dump_req_r;
  end
  // Compares each read answer with the oldest note in the queue.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  // Cuts a hung run short.
  initial begin
    #(40 * 8000);
    n_fail++;
    test_done;
  end
  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  initial begin
    tk(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(inta_n_r, 1'b1);
    rd(`CMD_WORD_ADDR, 34'h0);
    rd(`DUMP_ADDR_ADDR, 34'h0);
    rd(`CU_BASE_ADDR, 34'h0);
    $display("Test reset values done");
    for (i = 0; i < 5; i++) begin
      pulse(5'h10 >> i);
      chk(inta_n_r, 1'b0);
      rd(`STATUS_WORD_ADDR, {18'h0, st[i]});
      wr(`STATUS_WORD_ADDR, {16'h0, cl[i]}, 2'h0);
      tk(3);
      chk(inta_n_r, 1'b1);
      m = mk[i] | 16'($random(seed)) & 16'hFC00;
      wr(`CMD_WORD_ADDR, {16'h0, m}, 2'h0);
      pulse(5'h10 >> i);
      chk(inta_n_r, 1'b1);
      rd(`CMD_WORD_ADDR, {18'h0, m});
      wr(`CMD_WORD_ADDR, 32'h0, 2'h0);
      tk(3);
      chk(inta_n_r, 1'b0);
      wr(`STATUS_WORD_ADDR, {16'h0, cl[i]}, 2'h0);
      tk(3);
    end
    $display("Test source masks done");
    wr(`CMD_WORD_ADDR, 32'h0100, 2'h0);
    wr(`CMD_WORD_ADDR, 32'h0300, 2'h0);
    pulse(5'h10);
    chk(inta_n_r, 1'b1);
    rd(`CMD_WORD_ADDR, 34'h0100);
    rd(`STATUS_WORD_ADDR, 34'h8400);
    wr(`CMD_WORD_ADDR, 32'h0, 2'h0);
    tk(3);
    chk(inta_n_r, 1'b0);
    wr(`STATUS_WORD_ADDR, 32'h8400, 2'h0);
    tk(3);
    chk(inta_n_r, 1'b1);
    wr(`CMD_WORD_ADDR, 32'hFE00, 2'h0);
    tk(3);
    chk(inta_n_r, 1'b0);
    wr(`STATUS_WORD_ADDR, 32'h0400, 2'h0);
    wr(`CMD_WORD_ADDR, 32'h2000, 2'h0);
    tk(3);
    chk(inta_n_r, 1'b1);
    $display("Test global mask done");
    slow <= 1'b1;
    susp <= 1'b1;
    p = $random(seed);
    op(p, 16'h2010);
    chk(cnt[0], 1);
    chk(list_ptr_r, p);
    rd(`STATUS_WORD_ADDR, 34'h0080);
    wst(2'h1);
    chk(inta_n_r, 1'b1);
    slow <= 1'b0;
    susp <= 1'b0;
    op(p, 16'h2020);
    wst(2'h0);
    op(p, 16'h2020);
    op(p, 16'h2000);
    op(p, 16'h20F0);
    chk(cnt[1], 1);
    chk(cnt[3], 0);
    chk(cmd_unit_state, 2'h0);
    slow <= 1'b1;
    p = $random(seed);
    op(p, 16'h2030);
    wst(2'h3);
    chk({cnt[2], list_ptr_r}, {2'h1, p});
    wst(2'h0);
    p = $random(seed);
    op(p, 16'h2040);
    rd(`DUMP_ADDR_ADDR, {2'h0, p});
    op(~p, 16'h2050);
    chk({cnt[3], dump_addr_r}, {2'h1, p});
    op(~p, 16'h2060);
    rd(`CU_BASE_ADDR, {2'h0, ~p});
    rd(`STATUS_WORD_ADDR, 34'h2000);
    wr(`CMD_WORD_ADDR, 32'h0, 2'h0);
    tk(3);
    chk(inta_n_r, 1'b0);
    wr(`STATUS_WORD_ADDR, 32'h2000, 2'h0);
    $display("Test opcodes done");
    wr(8'h40, $random(seed), 2'h2);
    rd(8'h40, {2'h2, 32'h0});
    $display("Test unmapped address done");
    test_done;
  end
endmodule // test_lan_system_command_word
`default_nettype wire
